// ### logic/rpcg_top.sv
// run-mode peripheral clock gate with AXI4-Lite register slave
// assumes one 10 MHz clock, synchronous active-low reset, units honour o_unit_clk_en
// Functional notes
// - a set gating bit gives its unit the clock
// - a clear gating bit stops its unit's clock
// - access to an unclocked unit answers with a bus fault
// - all gating bits are zero after reset
// - run gating register sits at offset 0x104, reset value zero
// - bits 18, 17, 16 gate counter units 2, 1, 0
// - bit 14 gates two-wire unit 1, bit 12 two-wire unit 0
// - bit 5 gates sync serial unit 1, bit 4 unit 0
// - bits 2, 1, 0 gate async serial units 2, 1, 0
// - bits 15, 13, 11 to 6 and 3 are reserved and read zero
// - run register applies while running; sleep and deep-sleep registers otherwise
// - sleep registers apply only when auto gating is selected
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module rpcg_top #(
  parameter int NUM_UNITS = rpcg_pkg::NUM_UNITS,
  parameter int ADDR_W = rpcg_pkg::ADDR_W
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_sleep_req,
  input wire logic i_deepsleep_req,
  input wire logic [NUM_UNITS-1:0] i_unit_access,
  output logic [NUM_UNITS-1:0] o_unit_clk_en,
  output logic [NUM_UNITS-1:0] o_unit_fault,
  output logic o_irq
);
  typedef struct packed {
    logic [31:0] run_en;
    logic [31:0] slp_en;
    logic [31:0] dsl_en;
    logic auto_gate;
    logic [31:0] fault_sts;
    logic [31:0] fault_msk;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic [NUM_UNITS-1:0] eff_en;
  } rpcg_top_state_t;

  rpcg_top_state_t s;
  rpcg_top_state_t next_s;
  logic [NUM_UNITS-1:0] fault_vec;

  // byte-lane merge restricted to the writable bits of a register
  function automatic logic [31:0] rpcg_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lanes) | (data & lanes);
  endfunction : rpcg_merge

  // gather the per-unit bits of a register in unit order
  function automatic logic [NUM_UNITS-1:0] rpcg_pick(input logic [31:0] r);
    logic [NUM_UNITS-1:0] v;
    v = '0;
    for (int k = 0; k < NUM_UNITS; k++) begin
      v[k] = r[rpcg_pkg::UNIT_POS[k]];
    end
    return v;
  endfunction : rpcg_pick

  // spread unit-order bits back to register positions
  function automatic logic [31:0] rpcg_place(input logic [NUM_UNITS-1:0] v);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < NUM_UNITS; k++) begin
      r[rpcg_pkg::UNIT_POS[k]] = v[k];
    end
    return r;
  endfunction : rpcg_place

  function automatic logic rpcg_hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction : rpcg_hit

  always_comb begin
    logic [31:0] clr;
    logic [31:0] cfg_rd;
    logic wr_ok;
    logic rd_ok;
    clr = '0;
    cfg_rd = '0;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    next_s = s;

    // write channel: address and data may come in either order
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (i_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = i_awaddr;
    end
    if (i_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = i_wdata;
      next_s.wstrb = i_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      wr_ok = 1'b1;
      // reserved bits are masked off so a write there changes nothing
      if (rpcg_hit(s.awaddr, rpcg_pkg::RUN_EN_OFS)) begin
        next_s.run_en = rpcg_merge(s.run_en, s.wdata, s.wstrb, rpcg_pkg::GATE_MASK);
      end else if (rpcg_hit(s.awaddr, rpcg_pkg::SLP_EN_OFS)) begin
        next_s.slp_en = rpcg_merge(s.slp_en, s.wdata, s.wstrb, rpcg_pkg::GATE_MASK);
      end else if (rpcg_hit(s.awaddr, rpcg_pkg::DSL_EN_OFS)) begin
        next_s.dsl_en = rpcg_merge(s.dsl_en, s.wdata, s.wstrb, rpcg_pkg::GATE_MASK);
      end else if (rpcg_hit(s.awaddr, rpcg_pkg::CLK_CFG_OFS)) begin
        if (s.wstrb[rpcg_pkg::AUTO_GATE_BIT / 8]) begin
          next_s.auto_gate = s.wdata[rpcg_pkg::AUTO_GATE_BIT];
        end
      end else if (rpcg_hit(s.awaddr, rpcg_pkg::FAULT_STS_OFS)) begin
        clr = rpcg_merge('0, s.wdata, s.wstrb, rpcg_pkg::GATE_MASK);
      end else if (rpcg_hit(s.awaddr, rpcg_pkg::FAULT_MSK_OFS)) begin
        next_s.fault_msk = rpcg_merge(s.fault_msk, s.wdata, s.wstrb, rpcg_pkg::GATE_MASK);
      end else begin
        wr_ok = 1'b0;
      end
      next_s.bresp = wr_ok ? rpcg_pkg::RESP_OKAY : rpcg_pkg::RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // read channel
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (i_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      rd_ok = 1'b1;
      cfg_rd[rpcg_pkg::AUTO_GATE_BIT] = s.auto_gate;
      if (rpcg_hit(i_araddr, rpcg_pkg::RUN_EN_OFS)) begin
        next_s.rdata = s.run_en & rpcg_pkg::GATE_MASK;
      end else if (rpcg_hit(i_araddr, rpcg_pkg::SLP_EN_OFS)) begin
        next_s.rdata = s.slp_en & rpcg_pkg::GATE_MASK;
      end else if (rpcg_hit(i_araddr, rpcg_pkg::DSL_EN_OFS)) begin
        next_s.rdata = s.dsl_en & rpcg_pkg::GATE_MASK;
      end else if (rpcg_hit(i_araddr, rpcg_pkg::CLK_CFG_OFS)) begin
        next_s.rdata = cfg_rd;
      end else if (rpcg_hit(i_araddr, rpcg_pkg::FAULT_STS_OFS)) begin
        next_s.rdata = s.fault_sts;
      end else if (rpcg_hit(i_araddr, rpcg_pkg::FAULT_MSK_OFS)) begin
        next_s.rdata = s.fault_msk;
      end else begin
        next_s.rdata = '0;
        rd_ok = 1'b0;
      end
      next_s.rresp = rd_ok ? rpcg_pkg::RESP_OKAY : rpcg_pkg::RESP_SLVERR;
    end
    next_s.arready = !next_s.rvalid;

    // a fault in the same cycle as its clear keeps the bit set
    next_s.fault_sts = (s.fault_sts & ~clr) | rpcg_place(fault_vec);
    next_s.irq = |(next_s.fault_sts & next_s.fault_msk);

    // the pattern in force depends on power mode and the auto gating choice
    if (s.auto_gate && i_deepsleep_req) begin
      next_s.eff_en = rpcg_pick(s.dsl_en);
    end else if (s.auto_gate && i_sleep_req) begin
      next_s.eff_en = rpcg_pick(s.slp_en);
    end else begin
      next_s.eff_en = rpcg_pick(s.run_en);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s <= '0;
      s.run_en <= rpcg_pkg::GATE_RST;
      s.slp_en <= rpcg_pkg::GATE_RST;
      s.dsl_en <= rpcg_pkg::GATE_RST;
      s.auto_gate <= rpcg_pkg::AUTO_GATE_RST;
      s.fault_sts <= rpcg_pkg::STS_RST;
      s.fault_msk <= rpcg_pkg::MSK_RST;
    end else begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
    rpcg_unit_gate u_gate (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_en(s.eff_en[g]),
      .i_access(i_unit_access[g]),
      .o_clk_en(o_unit_clk_en[g]),
      .o_fault(fault_vec[g])
    );
  end

  assign o_unit_fault = fault_vec;
  assign o_awready = s.awready;
  assign o_wready = s.wready;
  assign o_bvalid = s.bvalid;
  assign o_bresp = s.bresp;
  assign o_arready = s.arready;
  assign o_rvalid = s.rvalid;
  assign o_rdata = s.rdata;
  assign o_rresp = s.rresp;
  assign o_irq = s.irq;

  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (s.run_en & ~rpcg_pkg::GATE_MASK) == 32'h0000_0000)
    else $error("reserved run gating bit became set");
  // first sampled edge after release sees the reset state, never the unknown start-up value
  a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $past(!i_nrst) |-> s.run_en == 32'h0000_0000 && s.eff_en == '0)
    else $error("gating bits not zero after reset");
  a_run_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !s.auto_gate |=> s.eff_en == rpcg_pick($past(s.run_en)))
    else $error("run pattern not applied without auto gating");
  a_sleep_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.auto_gate && i_sleep_req && !i_deepsleep_req |=> s.eff_en == rpcg_pick($past(s.slp_en)))
    else $error("sleep pattern not applied");
  a_fault_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    |fault_vec |=> (s.fault_sts & rpcg_place($past(fault_vec))) == rpcg_place($past(fault_vec)))
    else $error("fault event did not set status");
  a_irq_level: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    o_irq == |(s.fault_sts & s.fault_msk))
    else $error("interrupt out of step with masked status");

  // channel payloads hold while valid waits for ready; no new take overlaps an answer
  a_bresp_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.bvalid && !i_bready |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped before it was taken");
  a_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.rvalid && !i_rready |=> s.rvalid && $stable(s.rdata) && $stable(s.rresp))
    else $error("read response changed before it was taken");
  a_write_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.bvalid |-> !s.awready && !s.wready)
    else $error("write channel ready while a response is pending");
  a_read_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.rvalid |-> !s.arready)
    else $error("read address ready while read data is pending");
  a_run_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.aw_got && s.w_got && !s.bvalid && &s.wstrb && rpcg_hit(s.awaddr, rpcg_pkg::RUN_EN_OFS)
    |=> s.run_en == ($past(s.wdata) & rpcg_pkg::GATE_MASK))
    else $error("run gating write did not land on the writable bits");
  a_status_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.aw_got && s.w_got && !s.bvalid && &s.wstrb && fault_vec == '0
    && rpcg_hit(s.awaddr, rpcg_pkg::FAULT_STS_OFS)
    |=> (s.fault_sts & $past(s.wdata) & rpcg_pkg::GATE_MASK) == 32'h0000_0000)
    else $error("written one did not clear fault status");
  a_read_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.rvalid |-> (s.rdata & ~(rpcg_pkg::GATE_MASK | (32'h1 << rpcg_pkg::AUTO_GATE_BIT))) == '0)
    else $error("reserved bit read back as one");

  // mode selection: deep sleep wins, and with no sleep request the run pattern holds
  a_deep_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s.auto_gate && i_deepsleep_req |=> s.eff_en == rpcg_pick($past(s.dsl_en)))
    else $error("deep-sleep pattern not applied");
  a_awake_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !i_sleep_req && !i_deepsleep_req |=> s.eff_en == rpcg_pick($past(s.run_en)))
    else $error("run pattern not applied while awake");

  // unit-facing outputs: quiet after reset, faults only for units that were unclocked
  a_unit_reset: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    $past(!i_nrst) |-> o_unit_clk_en == '0 && o_unit_fault == '0 && !o_irq)
    else $error("unit enables or faults not clear after reset");
  a_fault_only_gated: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    |o_unit_fault |-> (o_unit_fault & ~$past(o_unit_clk_en)) == o_unit_fault)
    else $error("fault raised for a clocked unit");
endmodule : rpcg_top
`default_nettype wire

// ### logic/rpcg_pkg.sv
// constants for the run-mode peripheral clock gate: register map, field layout, resets
// assumes a 32-bit register bus with word-aligned registers
package rpcg_pkg;
  localparam int NUM_UNITS = 10;
  localparam int ADDR_W = 12;
  // byte offsets
  localparam logic [11:0] RUN_EN_OFS = 12'h104;
  localparam logic [11:0] SLP_EN_OFS = 12'h114;
  localparam logic [11:0] DSL_EN_OFS = 12'h124;
  localparam logic [11:0] CLK_CFG_OFS = 12'h060;
  localparam logic [11:0] FAULT_STS_OFS = 12'h200;
  localparam logic [11:0] FAULT_MSK_OFS = 12'h204;
  // reset values
  localparam logic [31:0] GATE_RST = 32'h0000_0000;
  localparam logic [31:0] STS_RST = 32'h0000_0000;
  localparam logic [31:0] MSK_RST = 32'h0000_0000;
  localparam logic AUTO_GATE_RST = 1'b0;
  // writable gating positions; every other bit is reserved and reads zero
  localparam logic [31:0] GATE_MASK = 32'h0007_5037;
  localparam int AUTO_GATE_BIT = 27;
  // unit index to bit position: async_serial_unit_0_gate..2, sync_serial_unit_0_gate..1, twowire0..1, counter0..2
  localparam int UNIT_POS [NUM_UNITS] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rpcg_pkg

// ### logic/rpcg_unit_gate.sv
// one peripheral's clock enable and bus-fault check
// assumes the unit uses o_clk_en as a synchronous clock enable on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module rpcg_unit_gate (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_en,
  input wire logic i_access,
  output logic o_clk_en,
  output logic o_fault
);
  typedef struct packed {
    logic clk_en;
    logic fault;
  } rpcg_gate_t;

  rpcg_gate_t s;
  rpcg_gate_t next_s;

  always_comb begin
    next_s = s;
    // a registered enable cannot glitch, unlike a combinational gate on the clock
    next_s.clk_en = i_en;
    // the check uses the enable the unit actually sees this cycle
    next_s.fault = i_access && !s.clk_en;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_clk_en = s.clk_en;
  assign o_fault = s.fault;

  a_gated_fault: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_access && !o_clk_en |=> o_fault)
    else $error("access to gated unit gave no fault");
  a_open_no_fault: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_access && o_clk_en |=> !o_fault)
    else $error("fault on access to clocked unit");
  a_enable_follow: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    !i_en ##1 !i_en |-> !o_clk_en)
    else $error("clock enable left on after gate bit cleared");
endmodule : rpcg_unit_gate
`default_nettype wire

// ### dv/rpcg_periph_model.sv
// gated peripheral units and their bus path, behavioural
// assumes the bench pulses i_fire for one cycle with target units in i_sel
`timescale 1ns/10ps
`default_nettype none
module rpcg_periph_model (
  input wire logic i_clk_sys,
  input wire logic i_fire,
  input wire logic [9:0] i_sel,
  output logic [9:0] o_access
);
  // software may aim at a unit it never enabled, so faults can be provoked
  always_ff @(posedge i_clk_sys) begin
    o_access <= i_fire ? i_sel : 10'h000;
  end
endmodule : rpcg_periph_model
`default_nettype wire

// ### dv/tb_run_mode_periph_clock_gate.sv
// self-checking bench for the run-mode peripheral clock gate
// assumes the AXI4-Lite slave answers as handed over; one 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_run_mode_periph_clock_gate;
  localparam int POS [10] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18};
  localparam logic [11:0] RUN = rpcg_pkg::RUN_EN_OFS;
  localparam logic [11:0] STS = rpcg_pkg::FAULT_STS_OFS;
  logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, slp, dsl, fire;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [9:0] sel, acc, clk_en, fault;
  logic [1:0] bresp, rresp, rsp;
  int miscompares, compares, cyc;

  rpcg_top DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awprot(3'h0),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arprot(3'h0), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_sleep_req(slp), .i_deepsleep_req(dsl), .i_unit_access(acc),
    .o_unit_clk_en(clk_en), .o_unit_fault(fault), .o_irq(irq));
  rpcg_periph_model u_units (.i_clk_sys(clk), .i_fire(fire), .i_sel(sel), .o_access(acc));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    // look just after the edge so whatever it launched has settled
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel released at the edge that takes it
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while ((awvalid && !ta) || (wvalid && !tw));
    do @(negedge clk); while (!bvalid);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : rdr

  // access pulse reaches the gate one edge after fire; fault is registered and checked after the next edge
  task automatic poke(input logic [9:0] s);
    @(posedge clk);
    fire <= 1'b1;
    sel <= s;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
  endtask : poke

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, slp, dsl, fire} = '0;
    {awaddr, araddr, wdata, wstrb, sel} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    tick(3);
    `CHK(clk_en, 0);
    rdr(RUN);
    `CHK(rd, 32'h0000_0000);
    `CHK(rsp, rpcg_pkg::RESP_OKAY);
    wr(RUN, 32'hFFFF_FFFF, 4'h4);
    `CHK(rsp, rpcg_pkg::RESP_OKAY);
    rdr(RUN);
    `CHK(rd, 32'h0007_0000);
    wr(RUN, 32'h0000_AFC8);
    rdr(RUN);
    `CHK(rd, 32'h0000_0000);
    wr(RUN, 32'hFFFF_FFFF);
    rdr(RUN);
    `CHK(rd, 32'h0007_5037);
    tick(3);
    `CHK(clk_en, 10'h3FF);
    wr(RUN, 32'h0);
    tick(3);
    poke(10'h3FF);
    `CHK(fault, 10'h3FF);
    `CHK(irq, 0);
    wr(rpcg_pkg::FAULT_MSK_OFS, 32'h0007_5037);
    tick(2);
    `CHK(irq, 1);
    rdr(STS);
    `CHK(rd, 32'h0007_5037);
    wr(STS, 32'h0007_5037);
    tick(2);
    `CHK(irq, 0);
    for (int k = 0; k < 10; k++) begin
      wr(RUN, 32'h1 << POS[k]);
      tick(3);
      `CHK(clk_en, 10'h1 << k);
      poke(10'h3FF);
      `CHK(fault, 10'h3FF ^ (10'h1 << k));
      rdr(STS);
      `CHK(rd, 32'h0007_5037 ^ (32'h1 << POS[k]));
      wr(STS, 32'h0007_5037);
    end
    rdr(RUN);
    wr(RUN, rd | 32'h0000_0010);
    rdr(RUN);
    `CHK(rd, 32'h0004_0010);
    rdr(12'h0F0);
    `CHK(rsp, rpcg_pkg::RESP_SLVERR);
    `CHK(rd, 32'h0);
    wr(12'h0F0, 32'h1);
    `CHK(rsp, rpcg_pkg::RESP_SLVERR);
    wr(RUN, 32'h1);
    wr(rpcg_pkg::SLP_EN_OFS, 32'h0000_1000);
    rdr(rpcg_pkg::SLP_EN_OFS);
    `CHK(rd, 32'h0000_1000);
    wr(rpcg_pkg::DSL_EN_OFS, 32'h0004_0000);
    @(posedge clk);
    slp <= 1'b1;
    tick(3);
    `CHK(clk_en, 10'h001);
    wr(rpcg_pkg::CLK_CFG_OFS, 32'h0800_0000);
    tick(3);
    `CHK(clk_en, 10'h020);
    rdr(rpcg_pkg::CLK_CFG_OFS);
    `CHK(rd, 32'h0800_0000);
    @(posedge clk);
    dsl <= 1'b1;
    tick(3);
    `CHK(clk_en, 10'h200);
    @(posedge clk);
    slp <= 1'b0;
    dsl <= 1'b0;
    tick(3);
    `CHK(clk_en, 10'h001);
    @(posedge clk);
    nrst <= 1'b0;
    tick(2);
    @(posedge clk);
    nrst <= 1'b1;
    tick(3);
    `CHK(clk_en, 0);
    rdr(RUN);
    `CHK(rd, 32'h0);
    end_sim();
  end
endmodule : tb_run_mode_periph_clock_gate
`default_nettype wire
